// file: upc_consts.svh
// Purpose: Shared constants for the upconverter profile control ends.
// Assumes: One 25 MHz core clock.
// Notes: Register offsets index the controller's own register map.
`ifndef UPC_CONSTS_SVH
`define UPC_CONSTS_SVH
`define UPC_ADDR_W 5
`define UPC_REG_CTRL 5'h00
`define UPC_REG_FTW_BASE 5'h08
`define UPC_REG_PHASE_AMP_BASE 5'h10
`define UPC_REG_INTERP 5'h01
`define UPC_REG_KEYING 5'h02
`define UPC_REG_RAM0 5'h03
`define UPC_REG_RAM1 5'h04
`define UPC_REG_RAM_RATE 5'h05
`define UPC_REG_PINS 5'h06
`define UPC_REG_STATUS 5'h07
`define UPC_CTRL_MODE_LSB 0
`define UPC_CTRL_AMP_EN 2
`define UPC_CTRL_Q_FIRST 3
`define UPC_CTRL_INV_SINC 4
`define UPC_CTRL_SINE_OUT 5
`define UPC_CTRL_INV_COMB_BYP 6
`define UPC_CTRL_COMB_CLR 7
`define UPC_CTRL_KEY_EN 8
`define UPC_CTRL_KEY_EXT 9
`define UPC_CTRL_KEY_AUTO 10
`define UPC_CTRL_RAMP_RELOAD 11
`define UPC_CTRL_RAM_EN 12
`define UPC_CTRL_RAM_DEST 13
`define UPC_CTRL_IO_UPDATE 14
`define UPC_RESET_INTERP 6'h01
`endif

// file: upc_pkg.sv
// Purpose: Types shared by both ends of the upconverter profile control.
// Assumes: Nothing beyond the constants header.
// Notes: Holds types only.
package upc_pkg;
    typedef enum logic [1:0] {
        UPC_MODE_TONE,
        UPC_MODE_QUAD,
        UPC_MODE_INTERP
    } upc_mode_t;
    typedef enum logic [1:0] {
        UPC_RAM_ONCE,
        UPC_RAM_LOOP,
        UPC_RAM_BOUNCE,
        UPC_RAM_HOLD
    } upc_ram_mode_t;
    typedef struct packed {
        logic [31:0] ftw;
        logic [15:0] phase;
        logic [13:0] amp;
    } upc_profile_t;
endpackage

// file: upc_link_if.sv
// Purpose: Pins and settings between the host controller and the upconverter control.
// Assumes: Both ends run on core_clk.
// Notes: Pins cross as if asynchronous; the device end synchronises the profile, key and direction pins but uses tx_enable and io_update directly.
`timescale 1ns/1ps
`default_nettype none
interface upc_link_if;
    logic [2:0] profile_sel;
    logic key_pin;
    logic ram_dir_pin;
    logic io_update;
    logic tx_enable;
    logic [15:0] ctrl;
    upc_pkg::upc_profile_t profile [8];
    logic [5:0] interp_rate;
    logic [7:0] out_scale;
    logic [15:0] ramp_period;
    logic [13:0] ramp_step;
    logic [9:0] ram_begin [2];
    logic [9:0] ram_final [2];
    logic [15:0] ram_rate;
    logic [3:0] ram_mode;
    logic [15:0] iq_data;
    logic iq_valid;
    logic comb_overflow;
    modport host (output profile_sel, key_pin, ram_dir_pin, io_update, tx_enable, ctrl, profile,
        interp_rate, out_scale, ramp_period, ramp_step, ram_begin, ram_final, ram_rate, ram_mode,
        iq_data, iq_valid, input comb_overflow);
    modport dev (input profile_sel, key_pin, ram_dir_pin, io_update, tx_enable, ctrl, profile,
        interp_rate, out_scale, ramp_period, ramp_step, ram_begin, ram_final, ram_rate, ram_mode,
        iq_data, iq_valid, output comb_overflow);
endinterface
`default_nettype wire

// file: upc_host.sv
// Purpose: Host end: holds settings written by software and drives the device pins.
// Assumes: Software port with one-cycle strobes and read data one cycle later.
// Notes: Interpolation rate writes are refused while transmit is enabled.
`include "upc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module upc_host (
    input wire logic core_clk,
    input wire logic reset,
    upc_link_if.host link,
    input wire logic [`UPC_ADDR_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    input wire logic [15:0] iq_in,
    input wire logic iq_in_valid
);
    logic [15:0] ctrl_reg;
    logic [5:0] interp_reg;
    logic [7:0] scale_reg;
    logic [15:0] period_reg;
    logic [13:0] step_reg;
    logic [9:0] rb_reg [2];
    logic [9:0] rf_reg [2];
    logic [15:0] rate_reg;
    logic [3:0] rmode_reg;
    logic [4:0] pins_reg;
    logic tx_reg;
    logic upd_reg;
    logic [15:0] iq_reg;
    logic iq_v_reg;
    upc_pkg::upc_profile_t prof_reg [8];
    wire sel_ctrl = sw_wr && sw_addr == `UPC_REG_CTRL;
    wire sel_interp = sw_wr && sw_addr == `UPC_REG_INTERP && !tx_reg;
    wire sel_pins = sw_wr && sw_addr == `UPC_REG_PINS;
    wire [31:0] rdata_next = sw_addr == `UPC_REG_CTRL ? {16'h0000, ctrl_reg} :
        sw_addr == `UPC_REG_INTERP ? {18'h00000, scale_reg, interp_reg} :
        sw_addr == `UPC_REG_PINS ? {26'h0000000, tx_reg, pins_reg} :
        sw_addr == `UPC_REG_STATUS ? {31'h00000000, link.comb_overflow} : 32'h00000000;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= 16'h0000;
            interp_reg <= `UPC_RESET_INTERP;
            scale_reg <= 8'h00;
            period_reg <= 16'h0000;
            step_reg <= 14'h0000;
            rate_reg <= 16'h0000;
            rmode_reg <= 4'h0;
            pins_reg <= 5'h00;
            tx_reg <= 1'b0;
            upd_reg <= 1'b0;
            sw_rdata <= 32'h00000000;
            iq_reg <= 16'h0000;
            iq_v_reg <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                rb_reg[i] <= 10'h000;
                rf_reg[i] <= 10'h000;
            end
            for (int i = 0; i < 8; i++) begin
                prof_reg[i] <= '0;
            end
        end else begin
            sw_rdata <= sw_rd ? rdata_next : 32'h00000000;
            upd_reg <= sw_wr && sw_addr == `UPC_REG_CTRL && sw_wdata[`UPC_CTRL_IO_UPDATE];
            iq_reg <= iq_in;
            iq_v_reg <= iq_in_valid;
            if (sel_ctrl) ctrl_reg <= sw_wdata[15:0];
            if (sel_interp) begin
                interp_reg <= sw_wdata[5:0];
                scale_reg <= sw_wdata[13:6];
            end
            if (sel_pins) begin
                pins_reg <= sw_wdata[4:0];
                tx_reg <= sw_wdata[5];
            end
            if (sw_wr && sw_addr == `UPC_REG_KEYING) begin
                period_reg <= sw_wdata[15:0];
                step_reg <= sw_wdata[29:16];
            end
            if (sw_wr && sw_addr == `UPC_REG_RAM0) begin
                rb_reg[0] <= sw_wdata[9:0];
                rf_reg[0] <= sw_wdata[25:16];
            end
            if (sw_wr && sw_addr == `UPC_REG_RAM1) begin
                rb_reg[1] <= sw_wdata[9:0];
                rf_reg[1] <= sw_wdata[25:16];
            end
            if (sw_wr && sw_addr == `UPC_REG_RAM_RATE) begin
                rate_reg <= sw_wdata[15:0];
                rmode_reg <= sw_wdata[19:16];
            end
            for (int i = 0; i < 8; i++) begin
                if (sw_wr && sw_addr == `UPC_REG_FTW_BASE + 5'(i)) prof_reg[i].ftw <= sw_wdata;
                if (sw_wr && sw_addr == `UPC_REG_PHASE_AMP_BASE + 5'(i)) begin
                    prof_reg[i].phase <= sw_wdata[15:0];
                    prof_reg[i].amp <= sw_wdata[29:16];
                end
            end
        end
    end
    assign link.ctrl = ctrl_reg;
    assign link.interp_rate = interp_reg;
    assign link.out_scale = scale_reg;
    assign link.ramp_period = period_reg;
    assign link.ramp_step = step_reg;
    assign link.ram_begin = rb_reg;
    assign link.ram_final = rf_reg;
    assign link.ram_rate = rate_reg;
    assign link.ram_mode = rmode_reg;
    assign link.profile_sel = pins_reg[2:0];
    assign link.key_pin = pins_reg[3];
    assign link.ram_dir_pin = pins_reg[4];
    assign link.tx_enable = tx_reg;
    assign link.io_update = upd_reg;
    assign link.iq_data = iq_reg;
    assign link.iq_valid = iq_v_reg;
    assign link.profile = prof_reg;
endmodule
`default_nettype wire

// file: upc_dev.sv
// Purpose: Device end: profile selection, amplitude keying, comb filter control and RAM playback.
// Assumes: Settings are stable core_clk signals; pins are asynchronous.
// Notes: The synthesizer datapath is outside; this block supplies its control words.
//
// Strobed register access and the register offsets were left to the implementer.
`include "upc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module upc_dev #(
    parameter int RAM_AW = 10
) (
    input wire logic core_clk,
    input wire logic reset,
    upc_link_if.dev link,
    output logic [31:0] core_ftw,
    output logic [15:0] core_phase,
    output logic [13:0] core_amp,
    output logic core_sine_sel,
    output logic core_inv_sinc_en,
    output logic core_inv_comb_en,
    output logic [5:0] core_interp,
    output logic [15:0] core_i,
    output logic [15:0] core_q,
    output logic core_iq_valid,
    output logic [RAM_AW-1:0] ram_addr,
    output logic ram_dest,
    output logic ram_active
);
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic [4:0] s3_reg;
    logic [4:0] pin_reg;
    logic [2:0] prof_prev_reg;
    logic [13:0] ramp_amp_reg;
    logic [15:0] ramp_cnt_reg;
    logic [15:0] half_reg;
    logic half_v_reg;
    logic ovf_reg;
    logic [15:0] ram_cnt_reg;
    logic ram_up_reg;
    logic [5:0] rate_prev_reg;
    logic tx_prev_reg;
    wire [15:0] ctrl = link.ctrl;
    wire [1:0] mode = ctrl[`UPC_CTRL_MODE_LSB +: 2];
    wire interp_mode = mode == 2'(upc_pkg::UPC_MODE_INTERP);
    // Pins count only when the last two stages agree.
    wire [4:0] pins_next = (s2_reg ^ s3_reg) & 5'h1F;
    wire [4:0] pins_clean = (pin_reg & pins_next) | (s3_reg & ~pins_next);
    wire [2:0] sel = pin_reg[2:0];
    wire key_pin = pin_reg[3];
    wire dir_pin = pin_reg[4];
    upc_pkg::upc_profile_t act;
    assign act = link.profile[sel];
    wire prof_change = sel != prof_prev_reg;
    wire ramp_reload = ctrl[`UPC_CTRL_RAMP_RELOAD] && (link.io_update || prof_change);
    wire key_on = ctrl[`UPC_CTRL_KEY_EXT] ? key_pin : 1'b1;
    wire [13:0] amp_target = ctrl[`UPC_CTRL_AMP_EN] ? act.amp : 14'h3FFF;
    wire [13:0] ramp_goal = key_on ? amp_target : 14'h0000;
    wire ramp_tick = ramp_cnt_reg == 16'h0000;
    wire [14:0] amp_up = {1'b0, ramp_amp_reg} + {1'b0, link.ramp_step};
    wire [13:0] amp_step_up = (amp_up > {1'b0, ramp_goal}) ? ramp_goal : amp_up[13:0];
    wire [13:0] amp_step_dn = (ramp_amp_reg < link.ramp_step || ramp_amp_reg - link.ramp_step < ramp_goal) ?
        ramp_goal : ramp_amp_reg - link.ramp_step;
    wire [13:0] ramp_amp_next = ramp_amp_reg < ramp_goal ? amp_step_up :
        ramp_amp_reg > ramp_goal ? amp_step_dn : ramp_amp_reg;
    wire [13:0] key_amp = !ctrl[`UPC_CTRL_KEY_EN] ? amp_target :
        ctrl[`UPC_CTRL_KEY_AUTO] ? ramp_amp_reg : (key_on ? amp_target : 14'h0000);
    wire [13:0] scale_amp = {link.out_scale, 6'h00};
    wire [13:0] amp_next = interp_mode ? scale_amp : key_amp;
    wire [5:0] interp_ok = link.interp_rate == 6'h00 ? 6'h01 : link.interp_rate;
    // A rate change during transmit is the usual overflow cause; latch it until cleared.
    wire ovf_set = link.tx_enable && tx_prev_reg && link.interp_rate != rate_prev_reg;
    wire [RAM_AW-1:0] seg_begin = link.ram_begin[ctrl[`UPC_CTRL_RAM_DEST]][RAM_AW-1:0];
    wire [RAM_AW-1:0] seg_final = link.ram_final[ctrl[`UPC_CTRL_RAM_DEST]][RAM_AW-1:0];
    wire [1:0] seg_mode = ctrl[`UPC_CTRL_RAM_DEST] ? link.ram_mode[3:2] : link.ram_mode[1:0];
    wire ram_step = ram_active && ram_cnt_reg == 16'h0000;
    wire at_end = dir_pin ? ram_addr == seg_final : ram_addr == seg_begin;
    wire [RAM_AW-1:0] ram_start = dir_pin ? seg_begin : seg_final;
    wire [RAM_AW-1:0] ram_addr_next = !at_end ? (dir_pin ? ram_addr + 1'b1 : ram_addr - 1'b1) :
        seg_mode == 2'(upc_pkg::UPC_RAM_LOOP) ? ram_start : ram_addr;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
            pin_reg <= 5'h00;
        end else begin
            s1_reg <= {link.ram_dir_pin, link.key_pin, link.profile_sel};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= pins_clean;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prof_prev_reg <= 3'h0;
            ramp_amp_reg <= 14'h0000;
            ramp_cnt_reg <= 16'h0000;
        end else begin
            prof_prev_reg <= sel;
            if (ramp_reload || ramp_tick) ramp_cnt_reg <= link.ramp_period;
            else ramp_cnt_reg <= ramp_cnt_reg - 16'h0001;
            if (ramp_tick) ramp_amp_reg <= ramp_amp_next;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            core_ftw <= 32'h00000000;
            core_phase <= 16'h0000;
            core_amp <= 14'h0000;
            core_sine_sel <= 1'b0;
            core_inv_sinc_en <= 1'b0;
            core_inv_comb_en <= 1'b0;
            core_interp <= `UPC_RESET_INTERP;
        end else begin
            core_ftw <= interp_mode ? 32'h00000000 : act.ftw;
            core_phase <= interp_mode ? 16'h0000 : act.phase;
            core_amp <= amp_next;
            core_sine_sel <= ctrl[`UPC_CTRL_SINE_OUT];
            core_inv_sinc_en <= ctrl[`UPC_CTRL_INV_SINC];
            core_inv_comb_en <= !ctrl[`UPC_CTRL_INV_COMB_BYP];
            core_interp <= interp_ok;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            half_reg <= 16'h0000;
            half_v_reg <= 1'b0;
            core_i <= 16'h0000;
            core_q <= 16'h0000;
            core_iq_valid <= 1'b0;
            ovf_reg <= 1'b0;
            rate_prev_reg <= `UPC_RESET_INTERP;
            tx_prev_reg <= 1'b0;
        end else begin
            core_iq_valid <= 1'b0;
            if (link.iq_valid) begin
                if (!half_v_reg) begin
                    half_reg <= link.iq_data;
                    half_v_reg <= 1'b1;
                end else begin
                    half_v_reg <= 1'b0;
                    core_i <= ctrl[`UPC_CTRL_Q_FIRST] ? link.iq_data : half_reg;
                    core_q <= ctrl[`UPC_CTRL_Q_FIRST] ? half_reg : link.iq_data;
                    core_iq_valid <= !ovf_reg;
                end
            end
            rate_prev_reg <= link.interp_rate;
            tx_prev_reg <= link.tx_enable;
            // Set wins over clear so a fresh overflow is never lost.
            if (ovf_set) ovf_reg <= 1'b1;
            else if (ctrl[`UPC_CTRL_COMB_CLR]) ovf_reg <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ram_addr <= '0;
            ram_cnt_reg <= 16'h0000;
            ram_active <= 1'b0;
            ram_dest <= 1'b0;
            ram_up_reg <= 1'b0;
        end else begin
            ram_dest <= ctrl[`UPC_CTRL_RAM_DEST];
            ram_up_reg <= dir_pin;
            ram_active <= ctrl[`UPC_CTRL_RAM_EN];
            if (!ctrl[`UPC_CTRL_RAM_EN] || ram_up_reg != dir_pin) begin
                ram_addr <= ram_start;
                ram_cnt_reg <= link.ram_rate;
            end else if (ram_step) begin
                ram_addr <= ram_addr_next;
                ram_cnt_reg <= link.ram_rate;
            end else if (ram_active) begin
                ram_cnt_reg <= ram_cnt_reg - 16'h0001;
            end
        end
    end
    assign link.comb_overflow = ovf_reg;
endmodule
`default_nettype wire

// file: upc_monitor.sv
// Purpose: Concurrent checks on the link and the device control outputs.
// Assumes: One core_clk domain, reset active high.
// Notes: Outputs lag settings by a cycle, so checks wait for them to hold still.
`include "upc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module upc_monitor (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] profile_sel,
    input wire logic [15:0] ctrl,
    input wire upc_pkg::upc_profile_t profile [8],
    input wire logic [5:0] interp_rate,
    input wire logic [7:0] out_scale,
    input wire logic comb_overflow,
    input wire logic [31:0] core_ftw,
    input wire logic [15:0] core_phase,
    input wire logic [13:0] core_amp,
    input wire logic core_sine_sel,
    input wire logic core_inv_sinc_en,
    input wire logic core_inv_comb_en,
    input wire logic [5:0] core_interp
);
    logic [3:0] sel_cnt;
    logic live_reg;
    wire logic is_tone = ctrl[1:0] == upc_pkg::UPC_MODE_TONE;
    wire logic is_interp = ctrl[1:0] == upc_pkg::UPC_MODE_INTERP;
    wire upc_pkg::upc_profile_t act = profile[profile_sel];
    // The select pins cross a synchroniser, so profile checks wait until it has settled.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sel_cnt <= 4'h0;
        end else if (!$stable(profile_sel)) begin
            sel_cnt <= 4'h0;
        end else if (sel_cnt != 4'hF) begin
            sel_cnt <= sel_cnt + 4'h1;
        end
    end
    // Follow checks skip the first edge after reset, where outputs still show reset values.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence settled_tone;
        sel_cnt >= 4'h6 && is_tone && !ctrl[`UPC_CTRL_KEY_EN] && $stable(ctrl) && $stable(act);
    endsequence
    sequence clearing;
        ctrl[`UPC_CTRL_COMB_CLR] && $stable(interp_rate);
    endsequence
    AST_PROFILE_FTW: assert property (settled_tone |-> core_ftw == act.ftw)
        else $error("tone frequency differs from the active profile");
    AST_PROFILE_PHASE: assert property (settled_tone |-> core_phase == act.phase)
        else $error("phase differs from the active profile");
    AST_PROFILE_AMP: assert property (settled_tone |->
        core_amp == (ctrl[`UPC_CTRL_AMP_EN] ? act.amp : 14'h3FFF))
        else $error("tone amplitude wrong for the amplitude enable setting");
    AST_PIN_SYNC: assert property (!$stable(profile_sel) && $stable(ctrl) |=> $stable(core_ftw) [*2])
        else $error("profile change reached the core without synchronisation");
    AST_SINE_SEL: assert property (live_reg && $stable(ctrl) |-> core_sine_sel == ctrl[`UPC_CTRL_SINE_OUT])
        else $error("sine select does not follow its setting");
    AST_INV_SINC: assert property (live_reg && $stable(ctrl) |-> core_inv_sinc_en == ctrl[`UPC_CTRL_INV_SINC])
        else $error("inverse sinc enable does not follow its setting");
    AST_INV_COMB: assert property (live_reg && $stable(ctrl) |-> core_inv_comb_en == !ctrl[`UPC_CTRL_INV_COMB_BYP])
        else $error("inverse comb enable does not follow the bypass setting");
    AST_INTERP_OUT: assert property (is_interp && !ctrl[`UPC_CTRL_KEY_EN] && $stable(ctrl) &&
        $stable(out_scale) |-> core_ftw == 32'h0 && core_phase == 16'h0 && core_amp == {out_scale, 6'h00})
        else $error("interpolating mode outputs wrong");
    AST_INTERP_RATE: assert property ($stable(interp_rate) && interp_rate != 6'h00 |->
        core_interp == interp_rate)
        else $error("interpolation rate not passed to the core");
    AST_OVF_CLEAR: assert property (clearing [*2] |-> !comb_overflow)
        else $error("overflow persists while clear is held");
endmodule
`default_nettype wire

// file: tb_upconverter_profile_control.sv
// Purpose: Drives both ends through the software port and checks the core outputs.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Pin writes are followed by a wait long enough for the synchroniser.
`include "upc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_upconverter_profile_control;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] sw_addr = 5'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic [31:0] sw_rdata;
    logic [31:0] v;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic iq_in_valid = 1'b0;
    logic [15:0] iq_in = 16'h0;
    logic [31:0] core_ftw;
    logic [15:0] core_phase, core_i, core_q;
    logic [13:0] core_amp;
    logic [5:0] core_interp;
    logic [9:0] ram_addr;
    logic core_sine_sel, core_inv_sinc_en, core_inv_comb_en, core_iq_valid, ram_dest, ram_active;
    int bad_count = 0;
    int checked = 0;
    upc_pkg::upc_profile_t p;
    upc_link_if link ();
    upc_host upc_host_i (.core_clk(core_clk), .reset(reset), .link(link), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .iq_in(iq_in),
        .iq_in_valid(iq_in_valid));
    upc_dev upc_dev_i (.core_clk(core_clk), .reset(reset), .link(link), .core_ftw(core_ftw),
        .core_phase(core_phase), .core_amp(core_amp), .core_sine_sel(core_sine_sel),
        .core_inv_sinc_en(core_inv_sinc_en), .core_inv_comb_en(core_inv_comb_en),
        .core_interp(core_interp), .core_i(core_i), .core_q(core_q), .core_iq_valid(core_iq_valid),
        .ram_addr(ram_addr), .ram_dest(ram_dest), .ram_active(ram_active));
    upc_monitor upc_monitor_i (.core_clk(core_clk), .reset(reset), .profile_sel(link.profile_sel),
        .ctrl(link.ctrl), .profile(link.profile), .interp_rate(link.interp_rate),
        .out_scale(link.out_scale), .comb_overflow(link.comb_overflow), .core_ftw(core_ftw),
        .core_phase(core_phase), .core_amp(core_amp), .core_sine_sel(core_sine_sel),
        .core_inv_sinc_en(core_inv_sinc_en), .core_inv_comb_en(core_inv_comb_en),
        .core_interp(core_interp));
    always #20 core_clk = ~core_clk;
    function automatic upc_pkg::upc_profile_t prof(input int n);
        return '{ftw: {8'(n), 24'hA5C3F1}, phase: {4'(n), 12'hF0F}, amp: {3'(n), 11'h2AA}};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1;
        v = sw_rdata;
    endtask
    // Pin changes need several cycles to cross into the device.
    task automatic pins(input logic [2:0] sel, input logic key, input logic dir, input logic tx);
        wr(`UPC_REG_PINS, {26'h0, tx, dir, key, sel});
        settle(8);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        settle(1);
        chk("reset rate", 32'(core_interp), 32'h1);
        for (int n = 0; n < 8; n++) begin
            p = prof(n);
            wr(`UPC_REG_FTW_BASE + 5'(n), p.ftw);
            wr(`UPC_REG_PHASE_AMP_BASE + 5'(n), {2'h0, p.amp, p.phase});
        end
        wr(`UPC_REG_CTRL, 32'h4);
        for (int n = 7; n >= 0; n--) begin
            p = prof(n);
            pins(3'(n), 1'b0, 1'b0, 1'b0);
            chk("ftw", core_ftw, p.ftw);
            chk("phase", 32'(core_phase), 32'(p.phase));
            chk("amp", 32'(core_amp), 32'(p.amp));
        end
        wr(`UPC_REG_CTRL, 32'h0);
        settle(2);
        chk("amp off", 32'(core_amp), 32'h3FFF);
        $display("test profiles done");
        for (int b = 4; b < 7; b++) begin
            wr(`UPC_REG_CTRL, 32'h1 << b);
            settle(2);
            chk("sinc", 32'(core_inv_sinc_en), 32'(b == 4));
            chk("sine", 32'(core_sine_sel), 32'(b == 5));
            chk("comb", 32'(core_inv_comb_en), 32'(b != 6));
        end
        $display("test settings done");
        wr(`UPC_REG_INTERP, {18'h0, 8'hA5, 6'h3F});
        wr(`UPC_REG_CTRL, 32'h2);
        settle(2);
        chk("interp ftw", core_ftw, 32'h0);
        chk("interp phase", 32'(core_phase), 32'h0);
        chk("scale", 32'(core_amp), 32'h2940);
        chk("rate 63", 32'(core_interp), 32'h3F);
        wr(`UPC_REG_INTERP, {18'h0, 8'h5A, 6'h01});
        settle(2);
        chk("rate 1", 32'(core_interp), 32'h1);
        pins(3'h0, 1'b0, 1'b0, 1'b1);
        wr(`UPC_REG_INTERP, {18'h0, 8'h11, 6'h05});
        rd(`UPC_REG_INTERP);
        chk("refused rate", v, {18'h0, 8'h5A, 6'h01});
        chk("core rate", 32'(core_interp), 32'h1);
        wr(`UPC_REG_CTRL, 32'h82);
        rd(`UPC_REG_STATUS);
        chk("overflow", v, 32'h0);
        pins(3'h0, 1'b0, 1'b0, 1'b0);
        $display("test interpolation done");
        p = prof(2);
        wr(`UPC_REG_CTRL, 32'h304);
        pins(3'h2, 1'b0, 1'b0, 1'b0);
        chk("key off", 32'(core_amp), 32'h0);
        pins(3'h2, 1'b1, 1'b0, 1'b0);
        chk("key on", 32'(core_amp), 32'(p.amp));
        wr(`UPC_REG_CTRL, 32'h704);
        wr(`UPC_REG_KEYING, {2'h0, 14'h0100, 16'h0003});
        settle(8);
        chk("ramping", 32'(core_amp < p.amp), 32'h1);
        settle(100);
        chk("ramp top", 32'(core_amp), 32'(p.amp));
        // Each io_update reloads the long ramp timer, so no step may land while they keep coming.
        wr(`UPC_REG_KEYING, {2'h0, 14'h3FFF, 16'h0028});
        wr(`UPC_REG_PINS, {26'h0, 1'b0, 1'b0, 1'b0, 3'h2});
        repeat (30) wr(`UPC_REG_CTRL, 32'h4F04);
        settle(1);
        chk("ramp held", 32'(core_amp), 32'(p.amp));
        settle(50);
        chk("ramp bottom", 32'(core_amp), 32'h0);
        $display("test keying done");
        wr(`UPC_REG_RAM0, {6'h0, 10'h009, 6'h0, 10'h004});
        wr(`UPC_REG_RAM1, {6'h0, 10'h009, 6'h0, 10'h004});
        wr(`UPC_REG_RAM_RATE, 32'h0);
        wr(`UPC_REG_CTRL, 32'h2000);
        pins(3'h0, 1'b0, 1'b1, 1'b0);
        chk("ram start up", 32'(ram_addr), 32'h4);
        chk("ram dest", 32'(ram_dest), 32'h1);
        pins(3'h0, 1'b0, 1'b0, 1'b0);
        chk("ram start down", 32'(ram_addr), 32'h9);
        pins(3'h0, 1'b0, 1'b1, 1'b0);
        wr(`UPC_REG_CTRL, 32'h3000);
        settle(20);
        chk("ram on", 32'(ram_active), 32'h1);
        chk("ram end", 32'(ram_addr), 32'h9);
        $display("test ram done");
        for (int q = 0; q < 2; q++) begin
            wr(`UPC_REG_CTRL, 32'(q) << 3);
            settle(1);
            @(posedge core_clk);
            iq_in <= 16'h1111;
            iq_in_valid <= 1'b1;
            @(posedge core_clk);
            iq_in <= 16'h2222;
            @(posedge core_clk);
            iq_in_valid <= 1'b0;
            for (int k = 0; k < 10; k++) begin
                settle(1);
                if (core_iq_valid === 1'b1) break;
            end
            chk("pair", 32'(core_iq_valid), 32'h1);
            chk("i", 32'(core_i), q ? 32'h2222 : 32'h1111);
            chk("q", 32'(core_q), q ? 32'h1111 : 32'h2222);
        end
        $display("test pairing done");
        conclude();
    end
endmodule
`default_nettype wire
